// >>> include/smc_pkg.sv
`default_nettype none

package smc_pkg;

  // ==========================================================================
  // Register bus
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_PORTS = 2;
  localparam int PORT_SEL_BIT = 4;
  localparam int REG_LSB = 0;
  localparam int REG_MSB = 3;
  localparam int MAP_LSB = 5;
  localparam logic [2:0] MAP_BASE = 3'h0;

  // Offsets inside one port window
  localparam logic [3:0] REG_DATA = 4'h0;
  localparam logic [3:0] REG_MODEM_CTRL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_DIVISOR = 4'hC;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_LOOP_BIT = 4;
  localparam int ST_TX_BUSY_BIT = 0;
  localparam int ST_RX_VALID_BIT = 1;
  localparam int ST_OVERRUN_BIT = 2;
  localparam int ST_FRAME_ERR_BIT = 3;
  localparam int ST_STRAP_LSB = 4;
  localparam int ST_STRAP_MSB = 5;

  // ==========================================================================
  // Character framing and reset values
  // ==========================================================================
  localparam int DIV_W = 16;
  localparam int CHAR_W = 8;
  localparam logic [3:0] TX_SHIFTS = 4'h9;
  localparam logic [3:0] RX_DATA_BITS = 4'h8;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic START_BIT = 1'b0;
  localparam logic STOP_BIT = 1'b1;
  localparam logic PIN_INACTIVE = 1'b1;
  localparam logic [DIV_W-1:0] DIVISOR_RESET = 16'h0010;
  localparam int SYNC_W = 4;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic {TX_IDLE, TX_SHIFT} smc_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} smc_rx_e;

  typedef struct packed {
    logic dtr;
    logic rts;
    logic loop;
    logic [DIV_W-1:0] divisor;
    smc_tx_e tx_st;
    logic [DIV_W-1:0] tx_cnt;
    logic [3:0] tx_bits;
    logic [CHAR_W:0] tx_shift;
    logic tx_line;
    smc_rx_e rx_st;
    logic [DIV_W-1:0] rx_cnt;
    logic [3:0] rx_bits;
    logic [CHAR_W-1:0] rx_shift;
    logic [CHAR_W-1:0] rx_data;
    logic rx_valid;
    logic overrun;
    logic frame_err;
    logic serial_out;
    logic req_send_n;
    logic term_ready_n;
  } smc_port_s;

endpackage : smc_pkg

`default_nettype wire

// >>> hw/smc_sync3.sv
`default_nettype none

module smc_sync3
  import smc_pkg::*;
(
  input wire logic clk_i,
  input wire logic [SYNC_W-1:0] d_i,
  output logic [SYNC_W-1:0] q_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] filt;
  } smc_sync_s;

  smc_sync_s q;
  smc_sync_s d;

  // No reset: straps must keep flowing through while reset is held
  always_comb begin
    d = q;
    d.s1 = d_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int k = 0; k < SYNC_W; k++) begin
      if (q.s2[k] == q.s3[k]) begin
        d.filt[k] = q.s3[k];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end

  assign q_o = q.filt;

endmodule // smc_sync3

`default_nettype wire

// >>> hw/smc_serial_pins.sv
// The implementer's own choices: strobed register access and the register addresses.
`default_nettype none

module smc_serial_pins
  import smc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic primary_serial_in_i,
  input wire logic secondary_serial_in_i,
  input wire logic second_port_addr_strap_lo_i,
  input wire logic second_port_addr_strap_hi_i,
  output logic primary_serial_out_o,
  output logic secondary_serial_out_o,
  output logic primary_req_send_out_o,
  output logic secondary_req_send_out_o,
  output logic primary_term_ready_out_o,
  output logic secondary_term_ready_out_o,
  output logic [1:0] secondary_addr_sel_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    smc_port_s [NUM_PORTS-1:0] port;
    logic [1:0] strap;
    logic [DATA_W-1:0] rdata;
  } smc_state_s;

  smc_state_s q;
  smc_state_s d;

  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_sync;
  logic [NUM_PORTS-1:0] rx_pin;
  logic [1:0] strap_pin;
  logic in_map;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  assign pin_raw = {second_port_addr_strap_hi_i,
                    second_port_addr_strap_lo_i,
                    secondary_serial_in_i,
                    primary_serial_in_i};

  smc_sync3 u_sync (
    .clk_i(clk_i),
    .d_i(pin_raw),
    .q_o(pin_sync)
  );

  assign rx_pin = pin_sync[NUM_PORTS-1:0];
  assign strap_pin = pin_sync[SYNC_W-1:NUM_PORTS];

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // A zero divisor would stall the bit timer, so it behaves as one
  function automatic logic [DIV_W-1:0] bit_len(input logic [DIV_W-1:0] div);
    logic [DIV_W-1:0] len;
    len = div;
    if (div == '0) begin
      len = {{(DIV_W-1){1'b0}}, 1'b1};
    end
    return len;
  endfunction

  function automatic smc_port_s port_reset();
    smc_port_s p;
    p = '0;
    p.divisor = DIVISOR_RESET;
    p.tx_st = TX_IDLE;
    p.rx_st = RX_IDLE;
    p.tx_line = LINE_IDLE;
    p.serial_out = LINE_IDLE;
    p.req_send_n = PIN_INACTIVE;
    p.term_ready_n = PIN_INACTIVE;
    return p;
  endfunction

  function automatic logic [DATA_W-1:0] read_port(
    input smc_port_s p,
    input logic [3:0] reg_a,
    input logic [1:0] strap
  );
    logic [DATA_W-1:0] r;
    r = '0;
    case (reg_a)
      REG_DATA: begin
        r[CHAR_W-1:0] = p.rx_data;
      end
      REG_MODEM_CTRL: begin
        r[MCR_DTR_BIT] = p.dtr;
        r[MCR_RTS_BIT] = p.rts;
        r[MCR_LOOP_BIT] = p.loop;
      end
      REG_STATUS: begin
        r[ST_TX_BUSY_BIT] = (p.tx_st != TX_IDLE);
        r[ST_RX_VALID_BIT] = p.rx_valid;
        r[ST_OVERRUN_BIT] = p.overrun;
        r[ST_FRAME_ERR_BIT] = p.frame_err;
        r[ST_STRAP_MSB:ST_STRAP_LSB] = strap;
      end
      REG_DIVISOR: begin
        r[DIV_W-1:0] = p.divisor;
      end
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  // ==========================================================================
  // One port: control bits, transmitter, receiver, pins
  // ==========================================================================
  function automatic smc_port_s step_port(
    input smc_port_s p,
    input logic rx_in,
    input logic sel,
    input logic wr,
    input logic rd,
    input logic [3:0] reg_a,
    input logic [DATA_W-1:0] wdata
  );
    smc_port_s n;
    logic [DIV_W-1:0] len;
    logic rx_bit;
    logic rx_done;
    logic data_wr;
    logic data_rd;
    n = p;
    len = bit_len(p.divisor);
    rx_done = 1'b0;
    data_wr = sel && wr && (reg_a == REG_DATA);
    data_rd = sel && rd && (reg_a == REG_DATA);
    // Loopback feeds the receiver from its own transmitter
    rx_bit = p.loop ? p.tx_line : rx_in;

    // Register writes
    if (sel && wr) begin
      case (reg_a)
        REG_MODEM_CTRL: begin
          n.dtr = wdata[MCR_DTR_BIT];
          n.rts = wdata[MCR_RTS_BIT];
          n.loop = wdata[MCR_LOOP_BIT];
        end
        REG_STATUS: begin
          if (wdata[ST_OVERRUN_BIT]) begin
            n.overrun = 1'b0;
          end
          if (wdata[ST_FRAME_ERR_BIT]) begin
            n.frame_err = 1'b0;
          end
        end
        REG_DIVISOR: begin
          n.divisor = wdata[DIV_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Transmitter: start bit, eight data bits, stop bit
    case (p.tx_st)
      TX_IDLE: begin
        n.tx_line = LINE_IDLE;
        // A write while busy is dropped; software polls the busy flag
        if (data_wr) begin
          n.tx_st = TX_SHIFT;
          n.tx_line = START_BIT;
          n.tx_shift = {STOP_BIT, wdata[CHAR_W-1:0]};
          n.tx_bits = TX_SHIFTS;
          n.tx_cnt = len - 16'h0001;
        end
      end
      TX_SHIFT: begin
        if (p.tx_cnt != '0) begin
          n.tx_cnt = p.tx_cnt - 16'h0001;
        end else if (p.tx_bits != '0) begin
          n.tx_line = p.tx_shift[0];
          n.tx_shift = {1'b0, p.tx_shift[CHAR_W:1]};
          n.tx_bits = p.tx_bits - 4'h1;
          n.tx_cnt = len - 16'h0001;
        end else begin
          n.tx_st = TX_IDLE;
          n.tx_line = LINE_IDLE;
        end
      end
      default: begin
        n.tx_st = TX_IDLE;
        n.tx_line = LINE_IDLE;
      end
    endcase

    // Receiver: sample each bit near its middle
    case (p.rx_st)
      RX_IDLE: begin
        if (rx_bit == START_BIT) begin
          n.rx_st = RX_START;
          // The detecting edge is the first cycle of the start bit,
          // so wait half a bit less one to land near its middle.
          // Below two clocks per bit the check falls on the first data bit.
          n.rx_cnt = (len - 16'h0001) >> 1;
        end
      end
      RX_START: begin
        if (p.rx_cnt != '0) begin
          n.rx_cnt = p.rx_cnt - 16'h0001;
        end else if (rx_bit == START_BIT) begin
          n.rx_st = RX_DATA;
          n.rx_bits = RX_DATA_BITS;
          n.rx_cnt = len - 16'h0001;
        end else begin
          // Glitch shorter than half a bit
          n.rx_st = RX_IDLE;
        end
      end
      RX_DATA: begin
        if (p.rx_cnt != '0) begin
          n.rx_cnt = p.rx_cnt - 16'h0001;
        end else begin
          n.rx_shift = {rx_bit, p.rx_shift[CHAR_W-1:1]};
          n.rx_bits = p.rx_bits - 4'h1;
          n.rx_cnt = len - 16'h0001;
          if (p.rx_bits == 4'h1) begin
            n.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (p.rx_cnt != '0) begin
          n.rx_cnt = p.rx_cnt - 16'h0001;
        end else begin
          n.rx_st = RX_IDLE;
          rx_done = 1'b1;
        end
      end
      default: begin
        n.rx_st = RX_IDLE;
      end
    endcase

    // Reading the data register consumes the character
    if (data_rd) begin
      n.rx_valid = 1'b0;
    end
    // A completed character wins over a clear in the same cycle
    if (rx_done) begin
      n.rx_data = p.rx_shift;
      n.rx_valid = 1'b1;
      if (p.rx_valid && !data_rd) begin
        n.overrun = 1'b1;
      end
      if (rx_bit != STOP_BIT) begin
        n.frame_err = 1'b1;
      end
    end

    // Pins come from flops; handshakes are low while their bit is set and loopback is off
    n.serial_out = n.loop ? LINE_IDLE : n.tx_line;
    n.req_send_n = ~(n.rts & ~n.loop);
    n.term_ready_n = ~(n.dtr & ~n.loop);
    return n;
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  assign in_map = (addr_i[ADDR_W-1:MAP_LSB] == MAP_BASE);

  always_comb begin
    d = q;
    for (int i = 0; i < NUM_PORTS; i++) begin
      d.port[i] = step_port(q.port[i],
                            rx_pin[i],
                            in_map && (addr_i[PORT_SEL_BIT] == i[0]),
                            wr_i,
                            rd_i,
                            addr_i[REG_MSB:REG_LSB],
                            wdata_i);
    end

    // Read data stand for exactly one cycle; unmapped reads give zero
    d.rdata = '0;
    if (rd_i && in_map) begin
      d.rdata = read_port(q.port[addr_i[PORT_SEL_BIT]], addr_i[REG_MSB:REG_LSB], q.strap);
    end

    if (rst_i) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        d.port[i] = port_reset();
      end
      d.rdata = '0;
      // Straps follow the pins for the whole reset and freeze at release
      d.strap = strap_pin;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign rdata_o = q.rdata;
  assign primary_serial_out_o = q.port[0].serial_out;
  assign secondary_serial_out_o = q.port[1].serial_out;
  assign primary_req_send_out_o = q.port[0].req_send_n;
  assign secondary_req_send_out_o = q.port[1].req_send_n;
  assign primary_term_ready_out_o = q.port[0].term_ready_n;
  assign secondary_term_ready_out_o = q.port[1].term_ready_n;
  assign secondary_addr_sel_o = q.strap;

endmodule // smc_serial_pins

`default_nettype wire

// >>> dv/smc_pins_checker.sv
`default_nettype none

module smc_pins_checker
  import smc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic primary_serial_out_o,
  input wire logic secondary_serial_out_o,
  input wire logic primary_req_send_out_o,
  input wire logic secondary_req_send_out_o,
  input wire logic primary_term_ready_out_o,
  input wire logic secondary_term_ready_out_o,
  input wire logic [1:0] secondary_addr_sel_o
);
  // ==========================================
  // Modem control writes per port
  // ==========================================
  logic wp;
  logic ws;
  assign wp = wr_i && addr_i == 8'h04;
  assign ws = wr_i && addr_i == 8'h14;

  default clocking cb @(posedge clk_i); endclocking

  rts_reset_a: assert property (rst_i |=> primary_req_send_out_o && secondary_req_send_out_o)
    else $error("request to send low in reset");
  dtr_reset_a: assert property (rst_i |=> primary_term_ready_out_o && secondary_term_ready_out_o)
    else $error("terminal ready low in reset");
  tx_reset_a: assert property (rst_i |=> primary_serial_out_o && secondary_serial_out_o)
    else $error("transmit line not idle in reset");
  rts_follow_a: assert property (disable iff (rst_i)
    wp && !wdata_i[MCR_LOOP_BIT] |=> primary_req_send_out_o == !$past(wdata_i[MCR_RTS_BIT]))
    else $error("request to send does not follow control bit");
  dtr_follow_a: assert property (disable iff (rst_i)
    ws && !wdata_i[MCR_LOOP_BIT] |=> secondary_term_ready_out_o == !$past(wdata_i[MCR_DTR_BIT]))
    else $error("terminal ready does not follow control bit");
  loop_hold_a: assert property (disable iff (rst_i)
    wp && wdata_i[MCR_LOOP_BIT] |=> primary_req_send_out_o && primary_term_ready_out_o)
    else $error("handshake active in loopback");
  pins_stable_a: assert property (disable iff (rst_i)
    !wp |=> $stable({primary_req_send_out_o, primary_term_ready_out_o}))
    else $error("handshake moved without control write");
  strap_freeze_a: assert property (disable iff (rst_i) !rst_i |=> $stable(secondary_addr_sel_o))
    else $error("strap latch moved after reset");

  cover property (wp && wdata_i[MCR_LOOP_BIT]);
  cover property (ws && !wdata_i[MCR_LOOP_BIT]);
  cover property (disable iff (rst_i) $fell(primary_serial_out_o));
endmodule // smc_pins_checker

bind smc_serial_pins smc_pins_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .primary_serial_out_o(primary_serial_out_o),
  .secondary_serial_out_o(secondary_serial_out_o), .primary_req_send_out_o(primary_req_send_out_o),
  .secondary_req_send_out_o(secondary_req_send_out_o), .primary_term_ready_out_o(primary_term_ready_out_o),
  .secondary_term_ready_out_o(secondary_term_ready_out_o), .secondary_addr_sel_o(secondary_addr_sel_o));

`default_nettype wire

// >>> dv/smc_modem_model.sv
`default_nettype none

module smc_modem_model (
  input wire logic clk_i,
  input wire logic serial_out_i,
  output logic serial_in_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Line idles at mark level between frames
  initial serial_in_o = 1'b1;

  // ==========================================
  // Drive one frame, LSB first
  // ==========================================
  task automatic send(input logic [7:0] b, input int div);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_in_o <= f[i];
      repeat (div) @(posedge clk_i);
    end
  endtask

  // Sampling on falling edges keeps clear of the launch edge
  task automatic grab(input int div, output logic [7:0] b);
    int n;
    n = 0;
    b = 8'h00;
    @(negedge clk_i);
    while (serial_out_i !== 1'b0 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(negedge clk_i);
      b[i] = serial_out_i;
    end
  endtask
endmodule // smc_modem_model

`default_nettype wire

// >>> dv/testbench.sv
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import smc_pkg::*;

  logic clk_i, rst_i, wr_i, rd_i, s_lo, s_hi, p_tx, s_tx, p_rx, s_rx, p_rts, s_rts, p_dtr, s_dtr;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o, w;
  logic [1:0] sel, st;
  logic [7:0] b, got;
  logic rd_d = 1'b0;
  logic [DATA_W-1:0] exp_q[$];
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;

  smc_serial_pins DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .primary_serial_in_i(p_rx), .secondary_serial_in_i(s_rx),
    .second_port_addr_strap_lo_i(s_lo), .second_port_addr_strap_hi_i(s_hi), .primary_serial_out_o(p_tx),
    .secondary_serial_out_o(s_tx), .primary_req_send_out_o(p_rts), .secondary_req_send_out_o(s_rts),
    .primary_term_ready_out_o(p_dtr), .secondary_term_ready_out_o(s_dtr), .secondary_addr_sel_o(sel));
  smc_modem_model m_pri (.clk_i(clk_i), .serial_out_i(p_tx), .serial_in_o(p_rx));
  smc_modem_model m_sec (.clk_i(clk_i), .serial_out_i(s_tx), .serial_in_o(s_rx));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================
  // Checking and closing
  // ==========================================
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    samples_checked++;
    if (seen !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_i) begin
    rd_d <= rd_i;
    if (rd_d) check("rdata", rdata_o, exp_q.pop_front());
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ==========================================
  // Bus and pin tasks
  // ==========================================
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  task automatic pins(input logic [3:0] e);
    @(negedge clk_i);
    check("handshake", {28'h0, p_rts, p_dtr, s_rts, s_dtr}, {28'h0, e});
  endtask

  initial begin
    void'($urandom(35231));
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    {s_hi, s_lo} = 2'($urandom());
    st = {s_hi, s_lo};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    pins(4'hF);
    check("idle tx", {30'h0, p_tx, s_tx}, 32'h3);
    check("strap", {30'h0, sel}, {30'h0, st});
    {s_hi, s_lo} <= ~st;
    rd(8'h18, {26'h0, st, 4'h0});
    rd(8'h04, 32'h0);
    rd(8'h0C, {16'h0, DIVISOR_RESET});
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      for (int v = 0; v < 4; v++) begin
        w = ($urandom() & 32'hFFFFFFE0) | v;
        wr({3'h0, p[0], REG_MODEM_CTRL}, w);
        if (p == 0) pins({~2'(v[1:0]), 2'h3});
        else pins({2'h0, ~2'(v[1:0])});
        rd({3'h0, p[0], REG_MODEM_CTRL}, 32'(v));
      end
      wr({3'h0, p[0], REG_MODEM_CTRL}, 32'h13);
      pins(p == 0 ? 4'hF : 4'h3);
      wr({3'h0, p[0], REG_MODEM_CTRL}, 32'h03);
    end
    pins(4'h0);
    $display("test handshake done");
    for (int p = 0; p < 2; p++) begin
      wr({3'h0, p[0], REG_DIVISOR}, 32'(p + 2));
      b = 8'($urandom());
      fork
        wr({3'h0, p[0], REG_DATA}, {24'h0, b});
        if (p == 0) m_pri.grab(2, got);
        else m_sec.grab(3, got);
      join
      check("tx byte", {24'h0, got}, {24'h0, b});
      b = 8'($urandom());
      if (p == 0) m_pri.send(b, 2);
      else m_sec.send(b, 3);
      repeat (12) @(posedge clk_i);
      rd({3'h0, p[0], REG_DATA}, {24'h0, b});
    end
    rd(8'hE4, 32'h0);
    $display("test serial done");
    st = 2'($urandom());
    {s_hi, s_lo} <= st;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    pins(4'hF);
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("strap again", {30'h0, sel}, {30'h0, st});
    $display("test second reset done");
    repeat (3) @(posedge clk_i);
    report_and_stop();
  end
endmodule // testbench

`default_nettype wire
